/* File: hw/shp_host_port.v */
// Operation
// - 8-bit shared mode reaches 65536 bytes
// - 16-bit shared mode reaches 32768 halfwords
// - fifo modes limit memory to 8K/16K/32K
// - client shared-register interrupt on port-3 bit
// - fifo interrupts on port-1 and port-2 bits
// - bus error interrupt on missing memory
// - cycle starts by select or dma ack
// - address bit 16 selects registers
// - client releases select after acknowledge
// - select cycles: direction high reads
// - dma cycles: direction high writes fifo
// - dma cycles ignore address, fifo only
// - dma enable turns address 15 into ack
// - requests on address 14 and 13
// - alternate routing ORs requests onto pin b
// - outbound request needs data and enable
// - inbound request needs room and enable
// - 8-bit mode uses data lines 15:8
// - 8-bit mode lower lines are inputs
// - pin b output or interrupt input
// - transceiver direction and enable driven
// - pin a low when pending, enabled, selected
// - register space map at 10000..10004
// - acknowledge as low ack or high ready
//
// shared memory host port: an external client reaches system RAM
// and two byte fifos. assumes a simple internal memory port with a
// done strobe and an error flag, and that the client obeys handshakes.
`timescale 1ns/10ps
`default_nettype none
`include "shp_defines.vh"

module shp_host_port
(
  // clock and reset
  input  wire        CLK,
  input  wire        RESET_N,
  // client bus pins
  input  wire        PORT_SELECT_N,
  input  wire        PORT_DIRECTION,
  input  wire [16:0] PORT_ADDRESS_IN,
  output wire [16:0] PORT_ADDRESS_OUT,
  output wire [16:0] PORT_ADDRESS_OE,
  input  wire [15:0] PORT_DATA_IN,
  output reg  [15:0] PORT_DATA_OUT,
  output wire [15:0] PORT_DATA_OE,
  output wire        CYCLE_ACK_OUT,
  output wire        TRANSCEIVER_ENABLE_N,
  output wire        TRANSCEIVER_DIRECTION,
  output wire        CLIENT_IRQ_A_N,
  input  wire        CLIENT_IRQ_B_IN,
  output wire        CLIENT_IRQ_B_OUT,
  output wire        CLIENT_IRQ_B_OE,
  // configuration
  input  wire        MODE_16BIT,
  input  wire        MODE_FIFO,
  input  wire        FIFO_DMA_ENABLE_N,
  input  wire        DMA_REQ_ALT_ROUTING,
  input  wire        ACK_AS_READY,
  input  wire        IRQ_B_IS_OUTPUT,
  input  wire [1:0]  FIFO_WINDOW,
  // internal processor side
  input  wire        HOST_IRQ_SET,
  output wire [7:0]  GP_INPUTS,
  output wire        IRQ_PORT3,
  output wire        IRQ_PORT1,
  output wire        IRQ_PORT2,
  output reg         IRQ_BUS_ERROR,
  input  wire        BUS_ERROR_CLEAR,
  input  wire        OUT_FIFO_WR,
  input  wire [7:0]  OUT_FIFO_WDATA,
  output wire        OUT_FIFO_FULL,
  input  wire        IN_FIFO_RD,
  output wire [7:0]  IN_FIFO_RDATA,
  output wire        IN_FIFO_EMPTY,
  // internal memory port
  output reg         MEM_REQ,
  output reg         MEM_WRITE,
  output reg  [15:0] MEM_ADDR,
  output reg  [15:0] MEM_WDATA,
  output reg         MEM_HALF,
  input  wire        MEM_DONE,
  input  wire        MEM_ERROR,
  input  wire [15:0] MEM_RDATA
);

  // states, one-hot
  localparam ST_IDLE = 5'h01;
  localparam ST_MEM  = 5'h02;
  localparam ST_REG  = 5'h04;
  localparam ST_WAIT = 5'h08; // one read-latency cycle for fifo data
  localparam ST_ACK  = 5'h10;

  reg        rst_m, rst_n;   // reset release pipeline
  wire       sel_n_s, dir_s, dack_n_s, irq_b_s; // synchronised controls
  wire [7:0] gp_s;           // synchronised general inputs
  reg  [4:0] state;          // cycle state
  reg        is_dma;         // current cycle is a dma cycle
  reg        is_read;        // current cycle drives data out
  reg  [15:0] rd_hold;       // read data for the client
  reg        client_irq;     // client to host, via shared register
  reg        pin_irq;        // client to host, via pin b rising edge
  reg        host_irq;       // host to client pending
  reg        glob_en, pin_sel; // pin a/b qualification
  reg        out_en, in_en;  // dma request enables
  reg        irq_b_d;        // pin b previous level
  reg        ack_on;         // acknowledge asserted

  // reset released through two flops; only constants under reset
  always @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      rst_m <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_m <= 1'b1;
      rst_n <= rst_m;
    end
  end

  wire dma_on = ~FIFO_DMA_ENABLE_N & MODE_FIFO;

  // control pins and pin b into CLK domain before decoding
  // pin b idles high after reset, so no false rising edge is seen
  shp_sync #(.W(4), .INIT(1'b1)) u_sync_ctl
  (
    .clk   (CLK),
    .rst_n (rst_n),
    .d     ({PORT_SELECT_N, PORT_DIRECTION, CLIENT_IRQ_B_IN,
             PORT_ADDRESS_IN[`SHP_A_DACK] | ~dma_on}),
    .q     ({sel_n_s, dir_s, irq_b_s, dack_n_s})
  );

  // lower data lines as general inputs in 8-bit mode
  shp_sync #(.W(8), .INIT(1'b0)) u_sync_gp
  (
    .clk   (CLK),
    .rst_n (rst_n),
    .d     (PORT_DATA_IN[7:0]),
    .q     (gp_s)
  );
  assign GP_INPUTS = MODE_16BIT ? 8'h00 : gp_s;

  // fifo pointers, one extra bit tells full from empty
  reg  [`SHP_FIFO_AW:0] ow, orp, iw, irp;
  wire [`SHP_FIFO_AW:0] o_cnt = ow - orp;
  wire [`SHP_FIFO_AW:0] i_cnt = iw - irp;
  wire out_empty = (o_cnt == 5'h00);
  wire in_full   = (i_cnt == `SHP_FIFO_DEPTH);
  assign OUT_FIFO_FULL = (o_cnt == `SHP_FIFO_DEPTH);
  assign IN_FIFO_EMPTY = (i_cnt == 5'h00);

  wire [7:0] out_rd;  // outbound data toward client
  wire       push_out = OUT_FIFO_WR & ~OUT_FIFO_FULL;
  wire       pop_in   = IN_FIFO_RD & ~IN_FIFO_EMPTY;
  reg        pop_out, push_in; // client side strobes
  reg  [7:0] push_in_data;

  // outbound fifo: host writes, client reads
  shp_fifo_mem u_out_mem
  (
    .clk   (CLK),
    .we    (push_out),
    .waddr (ow[`SHP_FIFO_AW-1:0]),
    .wdata (OUT_FIFO_WDATA),
    .raddr (orp[`SHP_FIFO_AW-1:0]),
    .rdata (out_rd)
  );

  // inbound fifo: client writes, host reads (read shows next cycle)
  shp_fifo_mem u_in_mem
  (
    .clk   (CLK),
    .we    (push_in),
    .waddr (iw[`SHP_FIFO_AW-1:0]),
    .wdata (push_in_data),
    .raddr (irp[`SHP_FIFO_AW-1:0]),
    .rdata (IN_FIFO_RDATA)
  );

  // pointer updates
  always @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ow  <= 5'h00;
      orp <= 5'h00;
      iw  <= 5'h00;
      irp <= 5'h00;
    end
    else
    begin
      if (push_out)
        ow <= ow + 5'h01;
      if (pop_out)
        orp <= orp + 5'h01;
      if (push_in)
        iw <= iw + 5'h01;
      if (pop_in)
        irp <= irp + 5'h01;
    end
  end

  // decode: address bit 16 picks registers over memory
  wire       start     = sel_n_s ^ dack_n_s; // exactly one asserted
  wire       reg_space = PORT_ADDRESS_IN[`SHP_A_REGSEL];
  wire [2:0] reg_idx   = PORT_ADDRESS_IN[2:0];
  wire [7:0] wr_byte   = MODE_16BIT ? PORT_DATA_IN[7:0] :
                                      PORT_DATA_IN[15:8];

  // memory window width in address bits
  reg [15:0] win_mask;
  always @*
  begin
    win_mask = 16'hffff; // full 64K bytes / 32K halfwords
    if (MODE_FIFO & dma_on)
    begin
      if (DMA_REQ_ALT_ROUTING)
        win_mask = 16'h7fff;  // 32K: only bit 15 taken by ack
      else if (FIFO_WINDOW == 2'h1)
        win_mask = 16'h3fff;  // 16K
      else
        win_mask = 16'h1fff;  // 8K: 15, 14, 13 taken
    end
    else if (MODE_FIFO)
      win_mask = (FIFO_WINDOW == 2'h2) ? 16'h7fff :
                 (FIFO_WINDOW == 2'h1) ? 16'h3fff : 16'h1fff;
  end

  // main cycle sequencer
  always @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state        <= ST_IDLE;
      is_dma       <= 1'b0;
      is_read      <= 1'b0;
      rd_hold      <= 16'h0000;
      MEM_REQ      <= 1'b0;
      MEM_WRITE    <= 1'b0;
      MEM_ADDR     <= 16'h0000;
      MEM_WDATA    <= 16'h0000;
      MEM_HALF     <= 1'b0;
      pop_out      <= 1'b0;
      push_in      <= 1'b0;
      push_in_data <= 8'h00;
      client_irq   <= 1'b0;
      host_irq     <= 1'b0;
      glob_en      <= 1'b0;
      pin_sel      <= 1'b0;
      out_en       <= 1'b0;
      in_en        <= 1'b0;
      IRQ_BUS_ERROR <= 1'b0;
      ack_on       <= 1'b0;
    end
    else
    begin
      pop_out <= 1'b0;
      push_in <= 1'b0;
      // host raises its interrupt toward the client
      if (HOST_IRQ_SET)
        host_irq <= 1'b1;
      if (BUS_ERROR_CLEAR)
        IRQ_BUS_ERROR <= 1'b0;
      case (state)
        ST_IDLE:
        begin
          ack_on <= 1'b0;
          if (start)
          begin
            is_dma <= ~dack_n_s;
            if (~dack_n_s)
            begin
              // dma: address ignored, fifo data only
              is_read <= ~dir_s;
              if (dir_s & MODE_FIFO & ~in_full)
              begin
                push_in      <= 1'b1;
                push_in_data <= wr_byte;
              end
              state <= ST_WAIT;
            end
            else
            begin
              is_read <= dir_s;
              if (reg_space)
                state <= ST_REG;
              else
              begin
                MEM_REQ   <= 1'b1;
                MEM_WRITE <= ~dir_s;
                MEM_HALF  <= MODE_16BIT;
                MEM_ADDR  <= PORT_ADDRESS_IN[15:0] & win_mask;
                MEM_WDATA <= MODE_16BIT ? PORT_DATA_IN :
                             {8'h00, PORT_DATA_IN[15:8]};
                state     <= ST_MEM;
              end
            end
          end
        end
        ST_MEM:
        begin
          if (MEM_DONE)
          begin
            MEM_REQ <= 1'b0;
            rd_hold <= MODE_16BIT ? MEM_RDATA : {MEM_RDATA[7:0], 8'h00};
            if (MEM_ERROR)
              IRQ_BUS_ERROR <= 1'b1; // set wins over clear
            state <= ST_ACK;
          end
        end
        ST_REG:
        begin
          // register space decode
          case (reg_idx)
            `SHP_REG_SHARED:
            begin
              rd_hold <= {3'h0, pin_sel, glob_en, host_irq, pin_irq,
                          client_irq, 8'h00};
              if (~is_read)
              begin
                client_irq <= wr_byte[`SHP_SH_CLIENT_IRQ];
                glob_en    <= wr_byte[`SHP_SH_GLOBAL_EN];
                pin_sel    <= wr_byte[`SHP_SH_PIN_SEL];
              end
              state <= ST_ACK;
            end
            `SHP_REG_CLEAR:
            begin
              rd_hold <= 16'h0000; // write only
              if (~is_read & ~HOST_IRQ_SET)
                host_irq <= 1'b0;
              state <= ST_ACK;
            end
            `SHP_REG_FIFO0, `SHP_REG_FIFO1:
            begin
              if (~is_read & MODE_FIFO & ~in_full)
              begin
                push_in      <= 1'b1;
                push_in_data <= wr_byte;
              end
              state <= ST_WAIT;
            end
            `SHP_REG_MASK:
            begin
              rd_hold <= {4'h0, ~in_full, ~out_empty, in_en, out_en, 8'h00};
              if (~is_read)
              begin
                out_en <= wr_byte[`SHP_MS_OUT_EN];
                in_en  <= wr_byte[`SHP_MS_IN_EN];
              end
              state <= ST_ACK;
            end
            default:
            begin
              rd_hold <= 16'h0000;
              state   <= ST_ACK;
            end
          endcase
        end
        ST_WAIT:
        begin
          // fifo read data is already registered at the read pointer
          if (is_read)
          begin
            rd_hold <= MODE_16BIT ? {8'h00, out_rd} : {out_rd, 8'h00};
            pop_out <= ~out_empty;
          end
          state <= ST_ACK;
        end
        ST_ACK:
        begin
          ack_on <= 1'b1;
          // hold until client releases its strobe
          if (sel_n_s & dack_n_s)
          begin
            ack_on <= 1'b0;
            state  <= ST_IDLE;
          end
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  // client interrupt in on pin b, rising edge sets flag
  always @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_b_d <= 1'b1;
      pin_irq <= 1'b0;
    end
    else
    begin
      irq_b_d <= irq_b_s;
      if (~IRQ_B_IS_OUTPUT & irq_b_s & ~irq_b_d)
        pin_irq <= 1'b1;
      else if (state == ST_REG && reg_idx == `SHP_REG_CLEAR && ~is_read)
        pin_irq <= 1'b0;
    end
  end

  // data out registered, drive only on read while ack is asserted
  always @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
      PORT_DATA_OUT <= 16'h0000;
    else
      PORT_DATA_OUT <= rd_hold;
  end
  wire drive = is_read & ack_on;
  assign PORT_DATA_OE = {{8{drive}}, {8{drive & MODE_16BIT}}};

  // acknowledge polarity: low ack or high ready
  assign CYCLE_ACK_OUT = ACK_AS_READY ? ack_on : ~ack_on;

  // transceiver controls
  assign TRANSCEIVER_DIRECTION = is_read & (state != ST_IDLE);
  assign TRANSCEIVER_ENABLE_N  = (state == ST_IDLE);

  // dma requests
  wire rq_out = dma_on & ~out_empty & out_en;
  wire rq_in  = dma_on & ~in_full & in_en;

  // requests on address 14/13 only without alt routing
  wire rq_pins = dma_on & ~DMA_REQ_ALT_ROUTING;
  assign PORT_ADDRESS_OUT = {2'b00, ~rq_out, ~rq_in, 13'h0000};
  assign PORT_ADDRESS_OE  = {2'b00, rq_pins, rq_pins, 13'h0000};

  // client interrupt pins qualified by enable and select
  wire pend = host_irq;
  assign CLIENT_IRQ_A_N = ~(pend & glob_en & ~pin_sel);
  wire alt = dma_on & DMA_REQ_ALT_ROUTING;
  assign CLIENT_IRQ_B_OUT = alt ? (rq_out | rq_in) :
                            ~(pend & glob_en & pin_sel);
  assign CLIENT_IRQ_B_OE  = alt | IRQ_B_IS_OUTPUT;

  // interrupts to the internal processor
  assign IRQ_PORT3 = client_irq | pin_irq;
  assign IRQ_PORT1 = MODE_FIFO & ~IN_FIFO_EMPTY;
  assign IRQ_PORT2 = MODE_FIFO & ~OUT_FIFO_FULL;

endmodule

`default_nettype wire

/* File: hw/shp_defines.vh */
// constants for the shared memory host port
// assumes inclusion by bare name from the design files
`ifndef SHP_DEFINES_VH
`define SHP_DEFINES_VH

// address map, register space selected by address bit 16
`define SHP_A_REGSEL      16
`define SHP_A_DACK        15
`define SHP_A_RQO         14
`define SHP_A_RQI         13
`define SHP_REG_SHARED    3'h0
`define SHP_REG_CLEAR     3'h1
`define SHP_REG_FIFO0     3'h2
`define SHP_REG_FIFO1     3'h3
`define SHP_REG_MASK      3'h4

// reachable memory windows, in address bits
`define SHP_AW_FULL       16
`define SHP_AW_8K         13
`define SHP_AW_16K        14
`define SHP_AW_32K        15

// fifo shape
`define SHP_FIFO_AW       4
`define SHP_FIFO_DEPTH    5'h10

// shared register fields
`define SHP_SH_CLIENT_IRQ 0
`define SHP_SH_PIN_IRQ    1
`define SHP_SH_HOST_IRQ   2
`define SHP_SH_GLOBAL_EN  3
`define SHP_SH_PIN_SEL    4

// mask/status register fields
`define SHP_MS_OUT_EN     0
`define SHP_MS_IN_EN      1
`define SHP_MS_OUT_NE     2
`define SHP_MS_IN_NF      3

`endif

/* File: hw/shp_sync.v */
// two flip-flop synchroniser for a bundle of level inputs
// assumes inputs come from outside the CLK domain
`timescale 1ns/10ps
`default_nettype none

module shp_sync
#(
  parameter W    = 1,
  parameter INIT = 1'b1
)
(
  // clock and reset
  input  wire         clk,
  input  wire         rst_n,
  // raw and synchronised levels
  input  wire [W-1:0] d,
  output reg  [W-1:0] q
);

  reg [W-1:0] meta; // first stage, read only by q

  // two stage capture, reset to idle level
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta <= {W{INIT}};
      q    <= {W{INIT}};
    end
    else
    begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule

`default_nettype wire

/* File: hw/shp_fifo_mem.v */
// small dual port byte memory for one fifo, registered read data
// assumes one clock, write and read addresses from fifo pointers
`timescale 1ns/10ps
`default_nettype none
`include "shp_defines.vh"

module shp_fifo_mem
(
  // clock
  input  wire                    clk,
  // write side
  input  wire                    we,
  input  wire [`SHP_FIFO_AW-1:0] waddr,
  input  wire [7:0]              wdata,
  // read side
  input  wire [`SHP_FIFO_AW-1:0] raddr,
  output reg  [7:0]              rdata
);

  reg [7:0] mem [0:(1<<`SHP_FIFO_AW)-1]; // storage, no reset needed

  // write port
  always @(posedge clk)
  begin
    if (we)
      mem[waddr] <= wdata;
  end

  // read data registered, valid one cycle after address
  always @(posedge clk)
  begin
    rdata <= mem[raddr];
  end

endmodule

`default_nettype wire

/* File: bench/shp_host_port_chk.sv */
// pin-level checker for the shared memory host port
// assumes it is bound onto shp_host_port, config held static
`timescale 1ns/10ps
`default_nettype none

module shp_host_port_chk
(
  // watched ports
  input wire logic        CLK,
  input wire logic        RESET_N,
  input wire logic        PORT_SELECT_N,
  input wire logic        PORT_DIRECTION,
  input wire logic [16:0] PORT_ADDRESS_IN,
  input wire logic [16:0] PORT_ADDRESS_OE,
  input wire logic [15:0] PORT_DATA_OE,
  input wire logic        CYCLE_ACK_OUT,
  input wire logic        TRANSCEIVER_ENABLE_N,
  input wire logic        TRANSCEIVER_DIRECTION,
  input wire logic        CLIENT_IRQ_B_OE,
  input wire logic        MODE_16BIT,
  input wire logic        FIFO_DMA_ENABLE_N,
  input wire logic        DMA_REQ_ALT_ROUTING,
  input wire logic        ACK_AS_READY,
  input wire logic        IRQ_B_IS_OUTPUT,
  input wire logic        IRQ_BUS_ERROR,
  input wire logic        MEM_REQ,
  input wire logic        MEM_DONE,
  input wire logic        MEM_ERROR
);
  // ack folded to active high, so both polarities share one check
  wire act = ACK_AS_READY ? CYCLE_ACK_OUT : !CYCLE_ACK_OUT;
  // dma ack only exists while address bit 15 is repurposed
  wire dma = !FIFO_DMA_ENABLE_N && !PORT_ADDRESS_IN[15];
  wire stb = !PORT_SELECT_N || dma;
  wire wrc = (!PORT_SELECT_N && !PORT_DIRECTION) || (dma && PORT_DIRECTION);

  default clocking @(posedge CLK); endclocking
  default disable iff (!RESET_N);

  property p_req_pins;
    !FIFO_DMA_ENABLE_N && !DMA_REQ_ALT_ROUTING |-> PORT_ADDRESS_OE[14:13] == 2'b11;
  endproperty
  a_req_pins: assert property (p_req_pins) else $error("request pins idle");
  property p_alt_pins;
    !FIFO_DMA_ENABLE_N && DMA_REQ_ALT_ROUTING
      |-> CLIENT_IRQ_B_OE && PORT_ADDRESS_OE[14:13] == 2'b00;
  endproperty
  a_alt_pins: assert property (p_alt_pins) else $error("alt routing wrong");
  property p_pin_b;
    !IRQ_B_IS_OUTPUT && !DMA_REQ_ALT_ROUTING |-> !CLIENT_IRQ_B_OE;
  endproperty
  a_pin_b: assert property (p_pin_b) else $error("pin b driven as input");
  property p_low_byte;
    !MODE_16BIT |-> PORT_DATA_OE[7:0] == 8'h00;
  endproperty
  a_low_byte: assert property (p_low_byte) else $error("low byte driven");
  property p_xcvr;
    act |-> !TRANSCEIVER_ENABLE_N && PORT_DATA_OE[15] == TRANSCEIVER_DIRECTION;
  endproperty
  a_xcvr: assert property (p_xcvr) else $error("transceiver wrong");
  property p_start;
    $rose(act) |-> $past(stb, 2);
  endproperty
  a_start: assert property (p_start) else $error("ack without strobe");
  property p_release;
    act && !stb |-> ##[1:5] !act;
  endproperty
  a_release: assert property (p_release) else $error("ack stuck");
  property p_write;
    act && wrc |-> PORT_DATA_OE == 16'h0000;
  endproperty
  a_write: assert property (p_write) else $error("bus driven on write");
  property p_buserr;
    $rose(IRQ_BUS_ERROR) |-> $past(MEM_DONE && MEM_ERROR);
  endproperty
  a_buserr: assert property (p_buserr) else $error("bus error cause");
  property p_memhold;
    MEM_REQ && !MEM_DONE |=> MEM_REQ;
  endproperty
  a_memhold: assert property (p_memhold) else $error("request dropped");

  // main scenarios reached
  c_dma: cover property (act && dma);
  c_mem: cover property (MEM_DONE && !MEM_ERROR);
  c_err: cover property ($rose(IRQ_BUS_ERROR));
endmodule

bind shp_host_port shp_host_port_chk u_chk
(
  .CLK, .RESET_N, .PORT_SELECT_N, .PORT_DIRECTION, .PORT_ADDRESS_IN,
  .PORT_ADDRESS_OE, .PORT_DATA_OE, .CYCLE_ACK_OUT, .TRANSCEIVER_ENABLE_N,
  .TRANSCEIVER_DIRECTION, .CLIENT_IRQ_B_OE, .MODE_16BIT,
  .FIFO_DMA_ENABLE_N, .DMA_REQ_ALT_ROUTING, .ACK_AS_READY,
  .IRQ_B_IS_OUTPUT, .IRQ_BUS_ERROR, .MEM_REQ, .MEM_DONE, .MEM_ERROR
);

`default_nettype wire

/* File: bench/shp_client_model.sv */
// external client: runs select and dma-ack cycles on the port pins
// assumes the bench resolves shared pins and calls cycle()
`timescale 1ns/10ps
`default_nettype none

module shp_client_model
(
  // clock and answer
  input  wire logic        clk,
  input  wire logic        ack,
  input  wire logic        ready_mode,
  input  wire logic [15:0] din,
  // driven pins
  output var  logic        sel_n,
  output var  logic        dir,
  output var  logic [16:0] addr,
  output var  logic [15:0] dout
);
  logic        ack_q;  // ack as seen at the last edge
  logic [15:0] rd_q;   // bus as seen at the last edge
  integer      to_cnt; // waits that ran out

  initial
  begin
    sel_n = 1'b1;
    dir = 1'b0;
    addr = 17'h08000;
    dout = 16'h0000;
    to_cnt = 0;
  end

  // sample at the edge, so the answer is taken where ack was seen
  always @(posedge clk)
  begin
    ack_q <= ready_mode ? ack : !ack;
    rd_q <= din;
  end

  task cycle(input logic dma, input logic d, input logic [16:0] a,
             input logic [15:0] wd, output logic [15:0] rd);
    integer n;
    begin
      @(posedge clk);
      #1;
      sel_n = dma;
      addr = dma ? {a[16], 1'b0, a[14:0]} : a;
      dir = d;
      dout = wd;
      n = 0;
      do begin @(posedge clk); #1; n = n + 1; end while (!ack_q && n < 300);
      rd = rd_q;
      sel_n = 1'b1;
      // released lines show garbage; bit 15 idles as inactive dma ack
      addr = ~a | 17'h08000;
      dout = ~wd;
      dir = ~d;
      do begin @(posedge clk); #1; n = n + 1; end while (ack_q && n < 600);
      if (n >= 300)
        to_cnt = to_cnt + 1;
    end
  endtask
endmodule

`default_nettype wire

/* File: bench/shp_host_port_bench.sv */
// self-checking bench for the shared memory host port
// assumes the client model, and a memory responder kept here
`timescale 1ns/10ps
`default_nettype none

module shp_host_port_bench;
  logic        CLK = 1'b0;
  logic        RESET_N = 1'b0;
  logic        m16 = 1'b1;
  logic        mfifo = 1'b0;
  logic        dma_n = 1'b1;
  logic        alt = 1'b0;
  logic        rdy = 1'b0;
  logic        b_mode = 1'b0;
  logic        b_drv = 1'b0;
  logic        hirq = 1'b0;
  logic        eclr = 1'b0;
  logic        of_wr = 1'b0;
  logic [7:0]  of_wd = 8'h00;
  logic        if_rd = 1'b0;
  logic        m_err = 1'b0;
  logic [15:0] m_data = 16'h0000;
  logic        MEM_DONE = 1'b0;
  logic        MEM_ERROR = 1'b0;
  logic        m_wr, m_half;
  logic [15:0] m_addr, m_wdata, v;
  integer      m_lat = 0;
  integer      cnt = 0;
  integer      i;
  integer      bad_count = 0;
  integer      checks = 0;
  wire         sel_n, dir, ack, b_oe, b_out, irq_a_n, xen_n, xdir;
  wire         irq3, irq1, irq2, berr, of_full, if_empty;
  wire         MEM_REQ, MEM_WRITE, MEM_HALF;
  wire  [16:0] cl_addr, a_out, a_oe;
  wire  [15:0] cl_data, d_out, d_oe, MEM_ADDR, MEM_WDATA;
  wire  [7:0]  gp, if_rdata;
  // shared pins: whoever enables wins
  wire  [16:0] pa = (a_oe & a_out) | (~a_oe & cl_addr);
  wire  [15:0] pd = (d_oe & d_out) | (~d_oe & cl_data);
  wire         pb = b_oe ? b_out : b_drv;

  shp_host_port dut (.CLK(CLK), .RESET_N(RESET_N), .PORT_SELECT_N(sel_n),
    .PORT_DIRECTION(dir), .PORT_ADDRESS_IN(pa), .PORT_ADDRESS_OUT(a_out),
    .PORT_ADDRESS_OE(a_oe), .PORT_DATA_IN(pd), .PORT_DATA_OUT(d_out),
    .PORT_DATA_OE(d_oe), .CYCLE_ACK_OUT(ack), .TRANSCEIVER_ENABLE_N(xen_n),
    .TRANSCEIVER_DIRECTION(xdir), .CLIENT_IRQ_A_N(irq_a_n),
    .CLIENT_IRQ_B_IN(pb), .CLIENT_IRQ_B_OUT(b_out), .CLIENT_IRQ_B_OE(b_oe),
    .MODE_16BIT(m16), .MODE_FIFO(mfifo), .FIFO_DMA_ENABLE_N(dma_n),
    .DMA_REQ_ALT_ROUTING(alt), .ACK_AS_READY(rdy), .IRQ_B_IS_OUTPUT(b_mode),
    .FIFO_WINDOW(2'h1), .HOST_IRQ_SET(hirq), .GP_INPUTS(gp),
    .IRQ_PORT3(irq3), .IRQ_PORT1(irq1), .IRQ_PORT2(irq2),
    .IRQ_BUS_ERROR(berr), .BUS_ERROR_CLEAR(eclr), .OUT_FIFO_WR(of_wr),
    .OUT_FIFO_WDATA(of_wd), .OUT_FIFO_FULL(of_full), .IN_FIFO_RD(if_rd),
    .IN_FIFO_RDATA(if_rdata), .IN_FIFO_EMPTY(if_empty), .MEM_REQ(MEM_REQ),
    .MEM_WRITE(MEM_WRITE), .MEM_ADDR(MEM_ADDR), .MEM_WDATA(MEM_WDATA),
    .MEM_HALF(MEM_HALF), .MEM_DONE(MEM_DONE), .MEM_ERROR(MEM_ERROR),
    .MEM_RDATA(m_data));

  shp_client_model cl (.clk(CLK), .ack(ack), .ready_mode(rdy), .din(pd),
    .sel_n(sel_n), .dir(dir), .addr(cl_addr), .dout(cl_data));

  initial forever #4 CLK = ~CLK;

  // memory responder: answers after m_lat cycles, records the request
  always @(posedge CLK)
  begin
    MEM_DONE <= 1'b0;
    cnt <= 0;
    if (MEM_REQ && !MEM_DONE)
    begin
      cnt <= cnt + 1;
      if (cnt >= m_lat)
      begin
        MEM_DONE <= 1'b1;
        MEM_ERROR <= m_err;
        m_wr <= MEM_WRITE;
        m_addr <= MEM_ADDR;
        m_wdata <= MEM_WDATA;
        m_half <= MEM_HALF;
      end
    end
  end

  task chk(input logic [31:0] s, input logic [31:0] e);
    checks = checks + 1;
    if (s !== e)
    begin
      bad_count = bad_count + 1;
      $display("ERROR at %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  task tick(input integer n);
    repeat (n) @(posedge CLK);
    #1;
  endtask

  task wr(input logic [16:0] a, input logic [15:0] d);
    cl.cycle(1'b0, 1'b0, a, d, v);
  endtask

  task conclude;
    $display("counts: %0d checks, %0d mismatches", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // hang guard, far beyond the several hundred cycles the tests take
  initial
  begin
    tick(30000);
    bad_count = bad_count + 1;
    conclude;
  end

  initial
  begin
    tick(6);
    RESET_N = 1'b1;
    tick(4);
    // 16-bit shared memory, prompt then slow memory
    wr(17'h07ffe, 16'ha55a);
    chk({m_wr, m_half, m_wdata}, {2'b11, 16'ha55a});
    m_lat = 7;
    m_data = 16'h3cc3;
    cl.cycle(1'b0, 1'b1, 17'h00100, 16'h0000, v);
    chk({m_wr, v}, {1'b0, 16'h3cc3});
    $display("test memory16 done");
    // 8-bit shared memory: top byte address, upper lanes only
    m16 = 1'b0;
    m_data = 16'hc3c3;
    wr(17'h0ffff, 16'h5a96);
    chk({m_half, m_addr}, {1'b0, 16'hffff});
    tick(4);
    chk(gp, 8'h69);
    cl.cycle(1'b0, 1'b1, 17'h00020, 16'h0000, v);
    chk(v[15:8], 8'hc3);
    // missing memory answers with an error
    m_err = 1'b1;
    wr(17'h00010, 16'h1111);
    chk(berr, 1'b1);
    m_err = 1'b0;
    eclr = 1'b1;
    tick(1);
    eclr = 1'b0;
    tick(1);
    chk(berr, 1'b0);
    $display("test memory8 done");
    // register space and client interrupts
    b_drv = 1'b1;
    tick(5);
    chk(irq3, 1'b1);
    wr(17'h10001, 16'h0000);
    chk(irq3, 1'b0);
    wr(17'h10000, 16'h0909);
    chk(irq3, 1'b1);
    hirq = 1'b1;
    tick(1);
    hirq = 1'b0;
    tick(2);
    chk(irq_a_n, 1'b0);
    wr(17'h10000, 16'h1818);
    b_mode = 1'b1;
    tick(2);
    chk({irq_a_n, b_oe, b_out, irq3}, 4'b1100);
    b_mode = 1'b0;
    $display("test registers done");
    // fifo mode with dma requests on the address pins
    mfifo = 1'b1;
    wr(17'h0ffff, 16'h0000);
    chk(m_addr, 16'h3fff);
    wr(17'h10004, 16'h0303);
    dma_n = 1'b0;
    tick(2);
    chk({a_oe[14:13], a_out[14:13]}, 4'b1110);
    chk({of_full, irq2, irq1}, 3'b010);
    of_wd = 8'h7e;
    of_wr = 1'b1;
    tick(1);
    of_wr = 1'b0;
    tick(2);
    chk(a_out[14], 1'b0);
    cl.cycle(1'b1, 1'b0, 17'h1abcd, 16'h0000, v);
    chk(v[15:8], 8'h7e);
    tick(2);
    chk(a_out[14], 1'b1);
    for (i = 0; i < 16; i = i + 1)
      cl.cycle(1'b1, 1'b1, 17'h15555, {i[7:0], 8'h00}, v);
    tick(2);
    chk({a_out[13], irq1}, 2'b11);
    for (i = 0; i < 16; i = i + 1)
    begin
      chk(if_rdata, i[7:0]);
      if_rd = 1'b1;
      tick(1);
      if_rd = 1'b0;
      tick(2);
    end
    chk({if_empty, a_out[13]}, 2'b10);
    alt = 1'b1;
    tick(2);
    chk({b_oe, b_out}, 2'b11);
    $display("test fifo done");
    // second reset into ready polarity
    RESET_N = 1'b0;
    mfifo = 1'b0;
    dma_n = 1'b1;
    alt = 1'b0;
    rdy = 1'b1;
    tick(6);
    RESET_N = 1'b1;
    tick(4);
    chk(ack, 1'b0);
    m_lat = 3;
    cl.cycle(1'b0, 1'b1, 17'h00200, 16'h0000, v);
    chk({v[15:8], cl.to_cnt[7:0]}, {8'hc3, 8'h00});
    $display("test ready done");
    conclude;
  end
endmodule

`default_nettype wire
